// file: core/adcsc_pkg.sv
// package for the converter sample and conversion control block
// assumes a 32-bit apb slave on ref_clk at 125 mhz, synchronous reset
package adcsc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] ADCSC_INSEL_OFS = 8'h04;
  localparam logic [7:0] ADCSC_STAT_OFS = 8'h08;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int ADCSC_ON_BIT = 15;
  localparam int ADCSC_TRIG_LSB = 5;
  localparam int ADCSC_AUTO_SAMPLE_BIT = 2;
  localparam int ADCSC_SAMPLE_BIT = 1;
  localparam int ADCSC_DONE_BIT = 0;

  // ----------------------------------------------------------------
  // input select register fields
  // ----------------------------------------------------------------
  localparam int ADCSC_NEG_B_BIT = 31;
  localparam int ADCSC_POS_B_LSB = 24;
  localparam int ADCSC_NEG_A_BIT = 23;
  localparam int ADCSC_POS_A_LSB = 16;
  localparam logic [31:0] ADCSC_INSEL_MASK = 32'hbfbf_0000;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ADCSC_INSEL_RST = 32'h0000_0000;
  localparam logic [2:0] ADCSC_TRIG_RST = 3'h0;

  // ----------------------------------------------------------------
  // trigger codes and positive input codes
  // ----------------------------------------------------------------
  localparam logic [2:0] ADCSC_TRIG_SW = 3'h0;
  localparam logic [2:0] ADCSC_TRIG_PIN = 3'h1;
  localparam logic [2:0] ADCSC_TRIG_TMR3 = 3'h2;
  localparam logic [2:0] ADCSC_TRIG_CHARGE = 3'h3;
  localparam logic [2:0] ADCSC_TRIG_AUTO = 3'h7;
  localparam logic [5:0] ADCSC_POS_TEMP = 6'h31;
  localparam logic [5:0] ADCSC_POS_IREF = 6'h30;

  // ----------------------------------------------------------------
  // timing: auto convert sampling length in ref_clk cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] ADCSC_AUTO_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    ADCSC_POS_ANALOG,
    ADCSC_POS_INT_REF,
    ADCSC_POS_TEMP_DIODE,
    ADCSC_POS_RESERVED
  } adcsc_pos_kind_type;

  typedef enum logic [1:0] {
    ADCSC_ST_IDLE,
    ADCSC_ST_SAMPLE,
    ADCSC_ST_CONVERT
  } adcsc_state_type;

endpackage

// file: core/adcsc_trig_if.sv
// interface between the control core and the trigger selector
// assumes both ends run on the same ref_clk
interface adcsc_trig_if;
  logic [2:0] trig_sel;
  logic sampling;
  logic fire;

  modport ctl (
    output trig_sel,
    output sampling,
    input fire
  );

  modport trg (
    input trig_sel,
    input sampling,
    output fire
  );
endinterface

// file: core/adcsc_trig.sv
// trigger selector: picks the event that ends sampling
// assumes charge unit and timer pulses on ref_clk, pin is asynchronous
module adcsc_trig (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_edge_pin,
  input wire logic charge_trig,
  input wire logic timer3_match,
  adcsc_trig_if.trg tif
);
  import adcsc_pkg::*;

  // ----------------------------------------------------------------
  // pin synchroniser and rising edge detect
  // ----------------------------------------------------------------
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic [7:0] auto_cnt_q;
  logic pin_edge;
  logic auto_end;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= ext_edge_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign pin_edge = pin_sync_q & ~pin_prev_q;

  // ----------------------------------------------------------------
  // internal sample counter for auto convert
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      auto_cnt_q <= 8'h00;
    end else if (!tif.sampling || auto_end) begin
      auto_cnt_q <= 8'h00;
    end else begin
      auto_cnt_q <= auto_cnt_q + 8'h01;
    end
  end

  assign auto_end = tif.sampling && (auto_cnt_q == ADCSC_AUTO_CYCLES - 8'h01);

  // ----------------------------------------------------------------
  // trigger selection; reserved codes never fire
  // ----------------------------------------------------------------
  always_comb begin
    tif.fire = 1'b0;
    if (tif.sampling) begin
      case (tif.trig_sel)
        ADCSC_TRIG_AUTO: tif.fire = auto_end; // R1
        ADCSC_TRIG_CHARGE: tif.fire = charge_trig; // R2
        ADCSC_TRIG_TMR3: tif.fire = timer3_match; // R3
        ADCSC_TRIG_PIN: tif.fire = pin_edge; // R4
        default: tif.fire = 1'b0; // R6
      endcase
    end
  end

endmodule

// file: core/adcsc_top.sv
// sample and conversion control for a successive approximation converter
// assumes an apb master on ref_clk, a converter core giving a done pulse
//
// Function
// R1: code 111 auto counter ends sampling
// R2: code 011 charge time unit ends sampling
// R3: code 010 timer three match ends sampling
// R4: code 001 pin edge ends sampling
// R5: code 000 software sample clear converts
// R6: reserved trigger codes give no trigger
// R7: software writing sample one starts sampling
// R8: auto sample sets sample bit by hardware
// R9: software zero to sample bit converts
// R10: selected trigger clears sample bit in hardware
// R11: hardware sets done when conversion ends
// R12: software clears done, never sets it
// R13: clearing done leaves activity running
// R14: new conversion clears done flag
// R15: avoid register access right after off
// R16: sample b negative input select bit
// R17: sample b positive input select field
// R18: sample a negative input select bit
// R19: unimplemented select bits read zero
// R20: sample a positive select, same coding
// R21: module on gates all sampling activity
//
// Local design decisions: the APB register port and the register addresses.
module adcsc_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_edge_pin,
  input wire logic charge_trig,
  input wire logic timer3_match,
  input wire logic conv_done,
  output logic sample_en,
  output logic convert_start,
  output logic neg_a_is_in1,
  output logic [5:0] pos_a_sel,
  output adcsc_pkg::adcsc_pos_kind_type pos_a_kind,
  output logic neg_b_is_in1,
  output logic [5:0] pos_b_sel,
  output adcsc_pkg::adcsc_pos_kind_type pos_b_kind
);
  import adcsc_pkg::*;

  localparam int AUTO_WAIT = 20;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic adcsc_pos_kind_type pos_kind(input logic [5:0] code);
    if (code == ADCSC_POS_TEMP) begin
      pos_kind = ADCSC_POS_TEMP_DIODE;
    end else if (code == ADCSC_POS_IREF) begin
      pos_kind = ADCSC_POS_INT_REF;
    end else if (code < ADCSC_POS_IREF) begin
      pos_kind = ADCSC_POS_ANALOG;
    end else begin
      pos_kind = ADCSC_POS_RESERVED;
    end
  endfunction

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  adcsc_trig_if tif ();
  adcsc_state_type state_q;
  adcsc_state_type state_d;
  logic on_q;
  logic [2:0] trig_sel_q;
  logic auto_sample_q;
  logic done_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic sample_en_q;
  logic convert_start_q;
  logic neg_a_q;
  logic neg_b_q;
  logic [5:0] pos_a_q;
  logic [5:0] pos_b_q;
  adcsc_pos_kind_type pos_a_kind_q;
  adcsc_pos_kind_type pos_b_kind_q;
  logic setup;
  logic access_done;
  logic wr_ctrl;
  logic wr_insel;
  logic any_hit;
  logic sw_sample_set;
  logic sw_sample_clr;
  logic end_evt;
  logic start_conv;
  logic done_set;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // trigger selector
  // ----------------------------------------------------------------
  assign tif.trig_sel = trig_sel_q;
  assign tif.sampling = on_q && (state_q == ADCSC_ST_SAMPLE);

  adcsc_trig u_trig (
    .ref_clk(ref_clk),
    .rst(rst),
    .ext_edge_pin(ext_edge_pin),
    .charge_trig(charge_trig),
    .timer3_match(timer3_match),
    .tif(tif.trg)
  );

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase after setup
  // ----------------------------------------------------------------
  assign setup = psel && !penable && !pready_q;
  assign access_done = psel && penable && pready_q;
  assign any_hit = reg_hit(paddr, ADCSC_CTRL_OFS) ||
                   reg_hit(paddr, ADCSC_INSEL_OFS) ||
                   reg_hit(paddr, ADCSC_STAT_OFS);
  assign wr_ctrl = access_done && pwrite && reg_hit(paddr, ADCSC_CTRL_OFS);
  assign wr_insel = access_done && pwrite && reg_hit(paddr, ADCSC_INSEL_OFS);

  always_comb begin
    rd_mux = 32'h0000_0000; // R19
    if (reg_hit(paddr, ADCSC_CTRL_OFS)) begin
      rd_mux[ADCSC_ON_BIT] = on_q;
      rd_mux[ADCSC_TRIG_LSB +: 3] = trig_sel_q;
      rd_mux[ADCSC_AUTO_SAMPLE_BIT] = auto_sample_q;
      rd_mux[ADCSC_SAMPLE_BIT] = (state_q == ADCSC_ST_SAMPLE);
      rd_mux[ADCSC_DONE_BIT] = done_q;
    end else if (reg_hit(paddr, ADCSC_INSEL_OFS)) begin
      rd_mux[ADCSC_NEG_B_BIT] = neg_b_q; // R16
      rd_mux[ADCSC_POS_B_LSB +: 6] = pos_b_q; // R17
      rd_mux[ADCSC_NEG_A_BIT] = neg_a_q; // R18
      rd_mux[ADCSC_POS_A_LSB +: 6] = pos_a_q; // R20
    end else if (reg_hit(paddr, ADCSC_STAT_OFS)) begin
      rd_mux[1:0] = state_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !any_hit;
      if (setup && !pwrite) begin
        prdata_q <= rd_mux;
      end else if (access_done) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      on_q <= 1'b0;
      trig_sel_q <= ADCSC_TRIG_RST;
      auto_sample_q <= 1'b0;
    end else if (wr_ctrl) begin
      on_q <= pwdata[ADCSC_ON_BIT];
      trig_sel_q <= pwdata[ADCSC_TRIG_LSB +: 3];
      auto_sample_q <= pwdata[ADCSC_AUTO_SAMPLE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // input select register; unimplemented bits are never stored
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neg_b_q <= ADCSC_INSEL_RST[ADCSC_NEG_B_BIT];
      pos_b_q <= ADCSC_INSEL_RST[ADCSC_POS_B_LSB +: 6];
      neg_a_q <= ADCSC_INSEL_RST[ADCSC_NEG_A_BIT];
      pos_a_q <= ADCSC_INSEL_RST[ADCSC_POS_A_LSB +: 6];
      pos_b_kind_q <= ADCSC_POS_ANALOG;
      pos_a_kind_q <= ADCSC_POS_ANALOG;
    end else if (wr_insel) begin
      neg_b_q <= pwdata[ADCSC_NEG_B_BIT]; // R16
      pos_b_q <= pwdata[ADCSC_POS_B_LSB +: 6]; // R17
      pos_b_kind_q <= pos_kind(pwdata[ADCSC_POS_B_LSB +: 6]); // R17
      neg_a_q <= pwdata[ADCSC_NEG_A_BIT]; // R18
      pos_a_q <= pwdata[ADCSC_POS_A_LSB +: 6]; // R20
      pos_a_kind_q <= pos_kind(pwdata[ADCSC_POS_A_LSB +: 6]); // R20
    end
  end

  // ----------------------------------------------------------------
  // sample and convert sequencer
  // ----------------------------------------------------------------
  assign sw_sample_set = wr_ctrl && pwdata[ADCSC_SAMPLE_BIT]; // R7
  assign sw_sample_clr = wr_ctrl && !pwdata[ADCSC_SAMPLE_BIT]; // R9
  assign end_evt = (trig_sel_q == ADCSC_TRIG_SW) ? sw_sample_clr // R5
                                                 : tif.fire; // R10
  assign done_set = on_q && (state_q == ADCSC_ST_CONVERT) && conv_done;

  always_comb begin
    state_d = state_q;
    start_conv = 1'b0;
    case (state_q)
      ADCSC_ST_IDLE: begin
        if (sw_sample_set || auto_sample_q) begin
          state_d = ADCSC_ST_SAMPLE; // R7 R8
        end
      end
      ADCSC_ST_SAMPLE: begin
        if (end_evt) begin
          start_conv = 1'b1;
          state_d = ADCSC_ST_CONVERT; // R10
        end
      end
      ADCSC_ST_CONVERT: begin
        if (conv_done) begin
          state_d = auto_sample_q ? ADCSC_ST_SAMPLE : ADCSC_ST_IDLE; // R8
        end
      end
      default: state_d = ADCSC_ST_IDLE;
    endcase
    if (!on_q) begin
      state_d = ADCSC_ST_IDLE; // R21
      start_conv = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ADCSC_ST_IDLE;
      sample_en_q <= 1'b0;
      convert_start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sample_en_q <= (state_d == ADCSC_ST_SAMPLE);
      convert_start_q <= start_conv;
    end
  end

  // ----------------------------------------------------------------
  // conversion complete flag: set beats any clear
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1; // R11
    end else if (start_conv) begin
      done_q <= 1'b0; // R14
    end else if (wr_ctrl && !pwdata[ADCSC_DONE_BIT]) begin
      done_q <= 1'b0; // R12 R13
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sample_en = sample_en_q;
  assign convert_start = convert_start_q;
  assign neg_a_is_in1 = neg_a_q;
  assign pos_a_sel = pos_a_q;
  assign pos_a_kind = pos_a_kind_q;
  assign neg_b_is_in1 = neg_b_q;
  assign pos_b_sel = pos_b_q;
  assign pos_b_kind = pos_b_kind_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_auto_convert: assert property ( // R1
    (state_q == ADCSC_ST_IDLE) ##1 (state_q == ADCSC_ST_SAMPLE && on_q &&
    trig_sel_q == ADCSC_TRIG_AUTO && !wr_ctrl)
    |-> ##[1:AUTO_WAIT] (convert_start_q || !on_q || wr_ctrl)
  ) else $error("auto convert did not start");

  chk_charge_trig: assert property ( // R2
    tif.sampling && trig_sel_q == ADCSC_TRIG_CHARGE && charge_trig
    |=> convert_start_q && state_q == ADCSC_ST_CONVERT
  ) else $error("charge unit trigger ignored");

  chk_timer_trig: assert property ( // R3
    tif.sampling && trig_sel_q == ADCSC_TRIG_TMR3 && timer3_match
    |=> convert_start_q && !sample_en_q
  ) else $error("timer trigger ignored");

  chk_pin_trig: assert property ( // R4
    tif.sampling && trig_sel_q == ADCSC_TRIG_PIN && $rose(u_trig.pin_sync_q)
    |=> convert_start_q
  ) else $error("pin edge trigger ignored");

  chk_sw_convert: assert property ( // R9
    tif.sampling && trig_sel_q == ADCSC_TRIG_SW && sw_sample_clr
    |=> convert_start_q ##1 (!convert_start_q && state_q != ADCSC_ST_SAMPLE)
  ) else $error("software clear did not convert");

  chk_sw_start: assert property ( // R7
    on_q && state_q == ADCSC_ST_IDLE && sw_sample_set
    |=> sample_en_q && state_q == ADCSC_ST_SAMPLE
  ) else $error("software start ignored");

  chk_auto_resample: assert property ( // R8
    done_set && auto_sample_q |=> sample_en_q && done_q
  ) else $error("auto sample did not restart");

  chk_done_clear: assert property ( // R14
    convert_start_q |-> !done_q
  ) else $error("done not cleared at conversion start");

  chk_clear_keeps: assert property ( // R13
    state_q == ADCSC_ST_CONVERT && on_q && !conv_done && wr_ctrl &&
    pwdata[ADCSC_ON_BIT] |=> state_q == ADCSC_ST_CONVERT
  ) else $error("done clear disturbed conversion");

  chk_insel_zero: assert property ( // R19
    setup && !pwrite && reg_hit(paddr, ADCSC_INSEL_OFS)
    |=> (prdata_q & ~ADCSC_INSEL_MASK) == 32'h0000_0000
  ) else $error("unimplemented select bits read nonzero");

  chk_off_idle: assert property ( // R21
    !on_q |=> !sample_en_q && !convert_start_q
  ) else $error("activity while module off");

  cov_auto_cycle: cover property (
    convert_start_q && trig_sel_q == ADCSC_TRIG_AUTO
  );
  cov_done_resample: cover property (done_set && auto_sample_q);
  cov_set_beats_clear: cover property (
    done_set && wr_ctrl && !pwdata[ADCSC_DONE_BIT]
  );

endmodule

// file: sim/adcsc_far.sv
// far-side model: converter core plus the three conversion trigger sources
// assumes ref_clk domain, kick codes from the bench: 1 pin, 2 timer, 3 charge
module adcsc_far (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] kick,
  input wire logic [7:0] lat,
  input wire logic convert_start,
  output logic conv_done,
  output logic ext_edge_pin,
  output logic charge_trig,
  output logic timer3_match
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic busy_q;
  logic [2:0] pin_q;

  // ------------------------------------------------------------
  // converter core: done pulse lat+1 cycles after the start pulse is sampled
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_done <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      conv_done <= 1'b0;
      if (convert_start) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
      end else if (busy_q) begin
        if (cnt_q == 8'h00) begin
          conv_done <= 1'b1;
          busy_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // trigger sources: one-cycle pulses, pin held high four cycles
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      charge_trig <= 1'b0;
      timer3_match <= 1'b0;
      pin_q <= 3'h0;
    end else begin
      charge_trig <= (kick == 2'h3);
      timer3_match <= (kick == 2'h2);
      if (kick == 2'h1) begin
        pin_q <= 3'h4;
      end else if (pin_q != 3'h0) begin
        pin_q <= pin_q - 3'h1;
      end
    end
  end
  assign ext_edge_pin = (pin_q != 3'h0);
endmodule

// file: sim/adcsc_top_test.sv
// self-checking bench for the sample and conversion control block
// assumes the apb slave answers without fixed latency, far model in adcsc_far
module adcsc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import adcsc_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, lat = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, d;
  logic pready, pslverr, ext_edge_pin, charge_trig, timer3_match, conv_done;
  logic sample_en, convert_start, neg_a_is_in1, neg_b_is_in1, er;
  logic [5:0] pos_a_sel, pos_b_sel;
  logic [1:0] kick = 2'h0;
  adcsc_pos_kind_type pos_a_kind, pos_b_kind;
  int checked = 0, mismatches = 0, seed = 2271, starts = 0, n;
  logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h7};
  logic [1:0] kicks [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [31:0] corner [3] = '{32'hffff_ffff, 32'hb1b0_ffff, 32'h3231_0000};

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (convert_start === 1'b1) starts <= starts + 1;

  adcsc_top u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_edge_pin(ext_edge_pin), .charge_trig(charge_trig),
    .timer3_match(timer3_match), .conv_done(conv_done),
    .sample_en(sample_en), .convert_start(convert_start),
    .neg_a_is_in1(neg_a_is_in1), .pos_a_sel(pos_a_sel),
    .pos_a_kind(pos_a_kind), .neg_b_is_in1(neg_b_is_in1),
    .pos_b_sel(pos_b_sel), .pos_b_kind(pos_b_kind));
  adcsc_far u_far (.ref_clk(ref_clk), .rst(rst), .kick(kick), .lat(lat),
    .convert_start(convert_start), .conv_done(conv_done),
    .ext_edge_pin(ext_edge_pin), .charge_trig(charge_trig),
    .timer3_match(timer3_match));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] kind_exp(input logic [5:0] c);
    if (c == 6'h31) return 2'h2;
    if (c == 6'h30) return 2'h1;
    if (c > 6'h31) return 2'h3;
    return 2'h0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
    chk("slave_error", 32'h0, {31'h0, er});
  endtask

  task automatic wait_start();
    int s0;
    s0 = starts;
    n = 0;
    while (starts == s0 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    chk("start_seen", 32'h1, {31'h0, n < 60});
  endtask

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #300000;
    mismatches++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd(ADCSC_CTRL_OFS, 32'h0, "ctrl_reset");
    rd(ADCSC_INSEL_OFS, ADCSC_INSEL_RST, "insel_reset");
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    $display("test reset done");

    for (int i = 0; i < 12; i++) begin
      d = (i < 3) ? corner[i] : $random(seed);
      wr(ADCSC_INSEL_OFS, d);
      rd(ADCSC_INSEL_OFS, d & ADCSC_INSEL_MASK, "insel_rb");
      chk("neg_b", {31'h0, d[31]}, {31'h0, neg_b_is_in1});
      chk("pos_b", {26'h0, d[29:24]}, {26'h0, pos_b_sel});
      chk("kind_b", 32'(kind_exp(d[29:24])), 32'(pos_b_kind));
      chk("neg_a", {31'h0, d[23]}, {31'h0, neg_a_is_in1});
      chk("pos_a", {26'h0, d[21:16]}, {26'h0, pos_a_sel});
      chk("kind_a", 32'(kind_exp(d[21:16])), 32'(pos_a_kind));
    end
    $display("test input select done");

    wr(ADCSC_CTRL_OFS, 32'h0000_8000);
    wr(ADCSC_CTRL_OFS, 32'h0000_8002);
    rd(ADCSC_STAT_OFS, 32'h1, "sampling_state");
    chk("sample_en_sw", 32'h1, {31'h0, sample_en});
    wr(ADCSC_CTRL_OFS, 32'h0000_8000);
    wait_start();
    chk("sw_start_prompt", 32'h1, {31'h0, n <= 3});
    repeat (6) @(posedge ref_clk);
    rd(ADCSC_CTRL_OFS, 32'h0000_8001, "done_set");
    wr(ADCSC_CTRL_OFS, 32'h0000_8001);
    rd(ADCSC_CTRL_OFS, 32'h0000_8001, "done_kept");
    wr(ADCSC_CTRL_OFS, 32'h0000_8000);
    rd(ADCSC_CTRL_OFS, 32'h0000_8000, "done_clr");
    wr(ADCSC_CTRL_OFS, 32'h0000_8001);
    rd(ADCSC_CTRL_OFS, 32'h0000_8000, "done_no_set");
    $display("test software trigger done");

    lat <= 8'h14;
    for (int i = 0; i < 4; i++) begin
      d = 32'h0000_8003 | (32'(codes[i]) << 5);
      wr(ADCSC_CTRL_OFS, d);
      if (codes[i] != 3'h7) begin
        rd(ADCSC_CTRL_OFS, d & ~32'h1 | {31'h0, i > 0}, "sample_control_set");
        @(posedge ref_clk);
        kick <= kicks[i];
        @(posedge ref_clk);
        kick <= 2'h0;
        wait_start();
      end else begin
        wait_start();
        chk("auto_len", 32'h1, {31'h0, n >= 14 && n <= 18});
      end
      @(posedge ref_clk);
      chk("sample_en_off", 32'h0, {31'h0, sample_en});
      rd(ADCSC_CTRL_OFS, d & 32'hffff_fffc, "hw_clear");
      rd(ADCSC_STAT_OFS, 32'h2, "convert_state");
      repeat (24) @(posedge ref_clk);
      rd(ADCSC_CTRL_OFS, d & 32'hffff_fffd, "done_after");
    end
    $display("test trigger sources done");

    wr(ADCSC_CTRL_OFS, 32'h0000_80e4);
    wait_start();
    wr(ADCSC_CTRL_OFS, 32'h0000_80e4);
    rd(ADCSC_STAT_OFS, 32'h2, "still_converting");
    repeat (24) @(posedge ref_clk);
    chk("auto_resample", 32'h1, {31'h0, sample_en});
    wait_start();
    wr(ADCSC_CTRL_OFS, 32'h0000_0000);
    @(posedge ref_clk);
    wr(ADCSC_CTRL_OFS, 32'h0000_0002);
    d = 32'(starts);
    repeat (30) @(posedge ref_clk);
    chk("off_idle", 32'h0, {31'h0, sample_en});
    chk("off_no_start", d, 32'(starts));
    rd(ADCSC_STAT_OFS, 32'h0, "off_state");
    $display("test auto sample and off done");
    tally_and_finish();
  end
endmodule
